// ---- design/uart_lmcs_pkg.sv ----
// Constants for the line and modem control and status block
package uart_lmcs_pkg;
   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_LINE_FORMAT = 8'h0C;
   localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_LINE_STATUS = 8'h14;
   localparam logic [7:0] ADDR_MODEM_STATUS = 8'h18;
   localparam logic [7:0] ADDR_CONTROL = 8'h1C;
   localparam logic [7:0] ADDR_DIVISOR = 8'h20;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int LF_STOP = 2;
   localparam int LF_PAR_EN = 3;
   localparam int LF_EVEN = 4;
   localparam int LF_FORCE = 5;
   localparam int LF_BREAK = 6;
   localparam int LF_DLAB = 7;
   localparam int MC_TERM = 0;
   localparam int MC_SEND = 1;
   localparam int MC_OUT1 = 2;
   localparam int MC_OUT2 = 3;
   localparam int MC_LOOP = 4;
   localparam int MC_IR = 6;
   localparam int MC_PRE4 = 7;
   localparam int CT_AUTO_CTS = 0;
   localparam int CT_FIFO_EN = 1;
   // ------------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------------
   localparam logic [7:0] LINE_FORMAT_RST = 8'h00;
   localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
   localparam logic [15:0] DIVISOR_RST = 16'h0001;
   localparam logic [3:0] OVERSAMPLE = 4'hF;
   localparam logic [1:0] PRESCALE4 = 2'h3;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_BRK} rx_state_t;
endpackage : uart_lmcs_pkg

// ---- design/uart_line_modem_control_status.sv ----
// Line and modem control and status logic of a serial transceiver
`timescale 1ns/100ps
module uart_line_modem_control_status
   import uart_lmcs_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rx_in,
   input wire logic clear_to_send_n,
   input wire logic dataset_ready_n,
   input wire logic call_alert_n,
   input wire logic carrier_detect_n,
   output logic tx_out,
   output logic terminal_ready_n,
   output logic send_request_n,
   output logic user_out1_n,
   output logic user_out2_n
);
   localparam int AW = $clog2(DEPTH);
   // ------------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------------
   logic wr_ff, rd_ff;
   logic [7:0] addr_ff;
   logic [7:0] line_format_reg_ff, modem_control_reg_ff, control_ff;
   logic [15:0] divisor_ff;
   logic [7:0] rd_val;
   wire logic take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         addr_ff <= 8'h00;
      end
      else
      begin
         wr_ff <= take & hwrite;
         rd_ff <= take & ~hwrite;
         addr_ff <= haddr[7:0];
      end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   wire logic dlab = line_format_reg_ff[LF_DLAB];
   wire logic wr_data = wr_ff & addr_ff == ADDR_DATA & ~dlab;
   wire logic wr_div = wr_ff & addr_ff == ADDR_DIVISOR & dlab;
   wire logic rd_data = rd_ff & addr_ff == ADDR_DATA & ~dlab;
   wire logic rd_lsr = rd_ff & addr_ff == ADDR_LINE_STATUS;
   wire logic rd_msr = rd_ff & addr_ff == ADDR_MODEM_STATUS;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         line_format_reg_ff <= LINE_FORMAT_RST;
         modem_control_reg_ff <= MODEM_CONTROL_RST;
         control_ff <= 8'h00;
         divisor_ff <= DIVISOR_RST;
      end
      else if (wr_ff)
      begin
         if (addr_ff == ADDR_LINE_FORMAT)
            line_format_reg_ff <= hwdata[7:0];
         if (addr_ff == ADDR_MODEM_CONTROL)
            modem_control_reg_ff <= hwdata[7:0];
         if (addr_ff == ADDR_CONTROL)
            control_ff <= hwdata[7:0];
         if (wr_div)
            divisor_ff <= hwdata[15:0];
      end
   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [4:0] pin_s1_ff, pin_s2_ff;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         pin_s1_ff <= 5'h1F;
         pin_s2_ff <= 5'h1F;
      end
      else
      begin
         pin_s1_ff <= {carrier_detect_n, call_alert_n, dataset_ready_n,
                       clear_to_send_n, rx_in};
         pin_s2_ff <= pin_s1_ff;
      end
   wire logic loop = modem_control_reg_ff[MC_LOOP];
   wire logic irda = modem_control_reg_ff[MC_IR];
   logic [3:0] modem_in;
   always_comb
   begin
      if (loop)
         modem_in = {modem_control_reg_ff[MC_OUT2],
                     modem_control_reg_ff[MC_OUT1],
                     modem_control_reg_ff[MC_TERM],
                     modem_control_reg_ff[MC_SEND]};
      else
         modem_in = ~pin_s2_ff[4:1];
   end
   // ------------------------------------------------------------------
   // Baud tick: /16 then optional /4 then divisor
   // ------------------------------------------------------------------
   logic [3:0] pre16_ff;
   logic [1:0] pre4_ff;
   logic [15:0] baud_cnt_ff;
   logic tick_ff;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         pre16_ff <= 4'h0;
         pre4_ff <= 2'h0;
         baud_cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= 1'b0;
         pre16_ff <= pre16_ff + 4'h1;
         if (pre16_ff == OVERSAMPLE)
         begin
            pre4_ff <= pre4_ff + 2'h1;
            if (!modem_control_reg_ff[MC_PRE4] || pre4_ff == PRESCALE4)
            begin
               if (baud_cnt_ff >= divisor_ff - 16'h0001)
               begin
                  baud_cnt_ff <= 16'h0000;
                  tick_ff <= 1'b1;
               end
               else
                  baud_cnt_ff <= baud_cnt_ff + 16'h0001;
            end
         end
      end
   // Tick is the 16x oversample rate of the serial line
   // ------------------------------------------------------------------
   // Character format
   // ------------------------------------------------------------------
   wire logic [3:0] nbits = 4'h5 + {2'b00, line_format_reg_ff[1:0]};
   wire logic par_en = line_format_reg_ff[LF_PAR_EN];
   function automatic logic par_of(input logic [7:0] d);
      logic p;
      p = ^d;
      if (line_format_reg_ff[LF_FORCE])
         par_of = ~line_format_reg_ff[LF_EVEN];
      else
         par_of = p ^ ~line_format_reg_ff[LF_EVEN];
   endfunction : par_of
   wire logic [7:0] len_mask = 8'hFF >> (4'h8 - nbits);
   // Stop length in half bits: 2, 3 or 4
   wire logic [2:0] stop_half = !line_format_reg_ff[LF_STOP] ? 3'h2 :
                                (line_format_reg_ff[1:0] == 2'b00 ? 3'h3
                                 : 3'h4);
   // ------------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------------
   tx_state_t tx_st_ff;
   logic [7:0] thr_ff;
   logic thr_full_ff;
   logic [10:0] tsr_ff;
   logic [3:0] tx_left_ff;
   logic [3:0] tx_sub_ff;
   logic tx_stop_ff;
   logic tx_ser;
   wire logic cts_hold = control_ff[CT_AUTO_CTS] & ~modem_in[0];
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         tx_st_ff <= TX_IDLE;
         thr_ff <= 8'h00;
         thr_full_ff <= 1'b0;
         tsr_ff <= 11'h7FF;
         tx_left_ff <= 4'h0;
         tx_sub_ff <= 4'h0;
         tx_stop_ff <= 1'b0;
      end
      else
      begin
         if (wr_data)
         begin
            thr_ff <= hwdata[7:0];
            thr_full_ff <= 1'b1;
         end
         unique case (tx_st_ff)
            TX_IDLE:
               if (thr_full_ff && !cts_hold && !wr_data)
               begin
                  // Parity sits right after the last data bit
                  tsr_ff <= {2'b11, thr_ff | ~len_mask, 1'b0} &
                     ~(11'(par_en & ~par_of(thr_ff & len_mask)) <<
                       (nbits + 4'h1));
                  tx_left_ff <= 4'h1 + nbits + {3'b000, par_en};
                  tx_sub_ff <= 4'h0;
                  tx_stop_ff <= 1'b0;
                  thr_full_ff <= 1'b0;
                  tx_st_ff <= TX_SHIFT;
               end
            TX_SHIFT:
               if (tick_ff)
               begin
                  tx_sub_ff <= tx_sub_ff + 4'h1;
                  if (tx_stop_ff && tx_sub_ff == 4'h7)
                  begin
                     tx_sub_ff <= 4'h0;
                     tx_left_ff <= tx_left_ff - 4'h1;
                     if (tx_left_ff == 4'h1)
                        tx_st_ff <= TX_IDLE;
                  end
                  else if (!tx_stop_ff && tx_sub_ff == OVERSAMPLE)
                  begin
                     tsr_ff <= {1'b1, tsr_ff[10:1]};
                     tx_left_ff <= tx_left_ff - 4'h1;
                     tx_sub_ff <= 4'h0;
                     if (tx_left_ff == 4'h1)
                     begin
                        tx_stop_ff <= 1'b1;
                        tx_left_ff <= {1'b0, stop_half};
                     end
                  end
               end
            default:
               tx_st_ff <= TX_IDLE;
         endcase
      end
   wire logic tx_busy = tx_st_ff == TX_SHIFT;
   assign tx_ser = line_format_reg_ff[LF_BREAK] ? 1'b0 :
                   (tx_busy & ~tx_stop_ff ? tsr_ff[0] : 1'b1);
   // Pulse encoder: a zero bit gives a pulse in the middle 3/16
   wire logic ir_pulse = ~tx_ser & tx_sub_ff >= 4'h7 & tx_sub_ff <= 4'h9;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         tx_out <= 1'b1;
         terminal_ready_n <= 1'b1;
         send_request_n <= 1'b1;
         user_out1_n <= 1'b1;
         user_out2_n <= 1'b1;
      end
      else
      begin
         if (loop)
            tx_out <= 1'b1;
         else if (irda)
            tx_out <= ir_pulse;
         else
            tx_out <= tx_ser;
         terminal_ready_n <= ~modem_control_reg_ff[MC_TERM];
         send_request_n <= ~modem_control_reg_ff[MC_SEND];
         user_out1_n <= ~modem_control_reg_ff[MC_OUT1];
         user_out2_n <= ~modem_control_reg_ff[MC_OUT2];
      end
   // ------------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------------
   // Decoder stretches a short high pulse to a whole low bit
   logic [4:0] ir_hold_ff;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         ir_hold_ff <= 5'h00;
      else if (pin_s2_ff[0] && tick_ff)
         ir_hold_ff <= 5'h10;
      else if (tick_ff && ir_hold_ff != 5'h00)
         ir_hold_ff <= ir_hold_ff - 5'h01;
   wire logic rx_ser = loop ? tx_ser :
                       (irda ? ir_hold_ff == 5'h00 : pin_s2_ff[0]);
   rx_state_t rx_st_ff;
   logic [3:0] rx_sub_ff, rx_cnt_ff;
   logic [8:0] rx_sr_ff;
   logic rx_brk_ok_ff;
   logic [10:0] fifo_ff [DEPTH];
   logic [AW:0] fcnt_ff;
   logic [AW-1:0] wp_ff, rp_ff;
   logic overrun_ff, err_sum_ff, thre_ff;
   wire logic fifo_mode = control_ff[CT_FIFO_EN];
   wire logic [AW:0] cap = fifo_mode ? (AW+1)'(DEPTH) : (AW+1)'(1);
   wire logic fifo_full = fcnt_ff >= cap;
   wire logic [3:0] rx_total = nbits + {3'b000, par_en};
   logic rx_done;
   logic [10:0] rx_word;
   always_comb
   begin
      logic [7:0] d;
      logic pb;
      d = 8'h00;
      pb = 1'b0;
      d = 8'((rx_sr_ff >> (4'h9 - rx_total)) & {1'b0, len_mask});
      pb = rx_sr_ff[8];
      rx_word = {1'b0, ~rx_ser, par_en & (pb != par_of(d)), d};
      rx_done = 1'b0;
      if (rx_st_ff == RX_SHIFT && tick_ff && rx_sub_ff == 4'h7 &&
          rx_cnt_ff == rx_total + 4'h1)
         rx_done = 1'b1;
   end
   // Framing error sits in bit 9, parity error in bit 8
   wire logic brk_frame = rx_done & ~rx_ser & rx_sr_ff == 9'h000;
   wire logic push = rx_done & ~fifo_full & ~(brk_frame & ~rx_brk_ok_ff);
   wire logic pop = rd_data & fcnt_ff != '0;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         rx_st_ff <= RX_IDLE;
         rx_sub_ff <= 4'h0;
         rx_cnt_ff <= 4'h0;
         rx_sr_ff <= 9'h000;
         rx_brk_ok_ff <= 1'b1;
      end
      else
         unique case (rx_st_ff)
            RX_IDLE:
               if (tick_ff && !rx_ser)
               begin
                  rx_st_ff <= RX_SHIFT;
                  rx_sub_ff <= 4'h0;
                  rx_cnt_ff <= 4'h0;
                  rx_sr_ff <= 9'h000;
               end
            RX_SHIFT:
               if (tick_ff)
               begin
                  rx_sub_ff <= rx_sub_ff + 4'h1;
                  if (rx_sub_ff == 4'h7)
                  begin
                     rx_cnt_ff <= rx_cnt_ff + 4'h1;
                     if (rx_cnt_ff != 4'h0 && !rx_done)
                        rx_sr_ff <= {rx_ser, rx_sr_ff[8:1]};
                     if (rx_done)
                     begin
                        rx_brk_ok_ff <= ~brk_frame;
                        rx_st_ff <= brk_frame ? RX_BRK : RX_IDLE;
                     end
                  end
               end
            RX_BRK:
               if (rx_ser)
               begin
                  rx_st_ff <= RX_IDLE;
                  rx_brk_ok_ff <= 1'b1;
               end
            default:
               rx_st_ff <= RX_IDLE;
         endcase
   always_ff @(posedge hclk)
      if (push)
         fifo_ff[wp_ff] <= {brk_frame, ~rx_ser & ~brk_frame,
                            rx_word[8:0]};
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
         fcnt_ff <= '0;
      end
      else
      begin
         if (push)
            wp_ff <= wp_ff + AW'(1);
         if (pop)
            rp_ff <= rp_ff + AW'(1);
         fcnt_ff <= fcnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   wire logic [10:0] head = fcnt_ff != '0 ? fifo_ff[rp_ff] : 11'h000;
   // ------------------------------------------------------------------
   // Status flags, set wins over clear
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         overrun_ff <= 1'b0;
         err_sum_ff <= 1'b0;
         thre_ff <= 1'b1;
      end
      else
      begin
         if (rx_done && fifo_full)
            overrun_ff <= 1'b1;
         else if (rd_lsr)
            overrun_ff <= 1'b0;
         if (push && (rx_word[8] || brk_frame || !rx_ser))
            err_sum_ff <= 1'b1;
         else if (rd_lsr)
            err_sum_ff <= 1'b0;
         if (tx_st_ff == TX_IDLE && thr_full_ff && !cts_hold && !wr_data)
            thre_ff <= 1'b1;
         else if (wr_data)
            thre_ff <= 1'b0;
      end
   wire logic temt = thre_ff & ~tx_busy;
   wire logic [7:0] lsr_val = {err_sum_ff, temt, thre_ff, head[10],
                               head[9], head[8], overrun_ff,
                               fcnt_ff != '0};
   logic [3:0] delta_ff;
   logic [3:0] min_old_ff;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         delta_ff <= 4'h0;
         min_old_ff <= 4'h0;
      end
      else
      begin
         min_old_ff <= modem_in;
         for (int i = 0; i < 4; i++)
         begin
            if (i == 2 ? (!modem_in[2] && min_old_ff[2]) :
                (modem_in[i] != min_old_ff[i]))
               delta_ff[i] <= 1'b1;
            else if (rd_msr)
               delta_ff[i] <= 1'b0;
         end
      end
   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   always_comb
   begin
      rd_val = 8'h00;
      if (addr_ff == ADDR_DATA && !dlab)
         rd_val = head[7:0];
      else if (addr_ff == ADDR_DIVISOR && dlab)
         rd_val = divisor_ff[7:0];
      else if (addr_ff == ADDR_LINE_FORMAT)
         rd_val = line_format_reg_ff;
      else if (addr_ff == ADDR_MODEM_CONTROL)
         rd_val = modem_control_reg_ff;
      else if (addr_ff == ADDR_LINE_STATUS)
         rd_val = lsr_val;
      else if (addr_ff == ADDR_MODEM_STATUS)
         rd_val = {modem_in, delta_ff};
      else if (addr_ff == ADDR_CONTROL)
         rd_val = control_ff;
   end
   assign hrdata = {24'h000000, rd_val};
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_break_low: assert property (@(posedge hclk) disable iff (!hresetn)
      line_format_reg_ff[LF_BREAK] && !loop && !irda |=> !tx_out)
      else $error("break not driving line low");
   chk_pins_inv: assert property (@(posedge hclk) disable iff (!hresetn)
      terminal_ready_n == ~$past(modem_control_reg_ff[MC_TERM]) &&
      user_out2_n == ~$past(modem_control_reg_ff[MC_OUT2]))
      else $error("modem pin sense wrong");
   chk_loop_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      loop ##1 loop |-> tx_out)
      else $error("pin not idle in loopback");
   chk_temt_rel: assert property (@(posedge hclk) disable iff (!hresetn)
      lsr_val[6] |-> !tx_busy && !thr_full_ff)
      else $error("transmitter empty while busy");
   chk_ready_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      push |=> lsr_val[0])
      else $error("data ready mismatch");
   chk_msr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_msr && $stable(modem_in) ##1 $stable(modem_in) |->
      delta_ff == 4'h0)
      else $error("change bits not cleared");
   chk_overrun: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_done && fifo_full |=> overrun_ff && $stable(wp_ff))
      else $error("overrun not flagged");
   chk_thre_clr: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_data |=> !thre_ff ##1 thr_full_ff || tx_busy)
      else $error("holding empty not cleared");
endmodule : uart_line_modem_control_status

// ---- tb/remote_line_model.sv ----
// Far-side serial device model: holds its line idle, samples transmit line
`timescale 1ns/100ps
module remote_line_model
(
   input wire logic hclk,
   input wire logic tx_out,
   input wire logic listen,
   output logic rx_in = 1'b1,
   output logic [9:0] got,
   output logic got_v = 1'b0
);
   // Only while listening, so a held break is not taken for a frame
   always @(posedge hclk)
      if (listen && tx_out === 1'b0)
      begin
         repeat (128) @(posedge hclk);
         for (int i = 0; i < 10; i++)
         begin
            repeat (256) @(posedge hclk);
            got[i] = tx_out;
         end
         got_v <= 1'b1;
         @(posedge hclk);
         got_v <= 1'b0;
      end
endmodule : remote_line_model

// ---- tb/test_uart_line_modem_control_status.sv ----
// Self-checking bench for the line and modem control and status block
`timescale 1ns/100ps
module test_uart_line_modem_control_status;
   import uart_lmcs_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, listen = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] mi = 4'hF, mo;
   logic [9:0] got, expq[$];
   logic [7:0] fmts[5] = '{8'h03, 8'h1B, 8'h0A, 8'h2B, 8'h3F};
   logic hreadyout, hresp, rx_in, tx_out, got_v;
   int miscompares = 0, comparisons = 0, seed = 59;
   always #20 hclk = ~hclk;
   uart_line_modem_control_status i_uart_line_modem_control_status (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_in, .tx_out,
      .clear_to_send_n(mi[0]), .dataset_ready_n(mi[1]),
      .call_alert_n(mi[2]), .carrier_detect_n(mi[3]),
      .terminal_ready_n(mo[0]), .send_request_n(mo[1]),
      .user_out1_n(mo[2]), .user_out2_n(mo[3]));
   remote_line_model i_remote_line_model (.hclk, .tx_out, .listen, .rx_in,
      .got, .got_v);
   task automatic chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Reads compare under mask; writes pass a zero mask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, m);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk iff hreadyout === 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk iff hreadyout === 1'b1);
      rd = hrdata;
      if (!w)
         chk(rd & m, d);
   endtask : bus
   // Frame after start bit: data LSB first, parity, then idle ones
   function automatic logic [9:0] mkf(input logic [7:0] f, d);
      logic [9:0] r;
      r = 10'h3FF;
      for (int i = 0; i < 5 + f[1:0]; i++)
         r[i] = d[i];
      if (f[3])
         r[5 + f[1:0]] = f[5] ? ~f[4] :
            ~(f[4] ^ (^(d & (8'hFF >> (3 - f[1:0])))));
      return r;
   endfunction : mkf
   task automatic end_of_test(input int extra);
      miscompares += extra;
      $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   always @(posedge hclk)
      if (got_v === 1'b1)
         chk(got, expq.pop_front());
   // Hang guard, well past seven frame times
   initial #3000000 end_of_test(1);
   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({tx_out, mo}, 5'h1F);
      bus(1'b0, ADDR_LINE_STATUS, 32'h60, 32'hFF);
      for (int i = 0; i < 4; i++)
      begin
         mi[i] <= 1'b0;
         repeat (4) @(posedge hclk);
         bus(1'b0, ADDR_MODEM_STATUS, (32'h10 | (i != 2)) << i, 32'hFF);
         mi[i] <= 1'b1;
         repeat (4) @(posedge hclk);
         bus(1'b0, ADDR_MODEM_STATUS, 32'h1 << i, 32'hFF);
      end
      v = $random(seed);
      bus(1'b1, ADDR_MODEM_CONTROL, v & 32'hF, '0);
      repeat (2) @(posedge hclk);
      chk(mo, ~v[3:0] & 4'hF);
      bus(1'b1, ADDR_MODEM_CONTROL, v & 32'hF | 32'h10, '0);
      repeat (4) @(posedge hclk);
      bus(1'b0, ADDR_MODEM_STATUS, {v[3:2], v[0], v[1], 4'h0}, 32'hF0);
      bus(1'b1, ADDR_LINE_FORMAT, 32'h1B, '0);
      bus(1'b1, ADDR_DATA, v & 32'hFF, '0);
      repeat (600) @(posedge hclk);
      chk(tx_out, 1'b1);
      repeat (2800) @(posedge hclk);
      bus(1'b0, ADDR_LINE_STATUS, 32'h61, 32'hFF);
      bus(1'b0, ADDR_DATA, v & 32'hFF, 32'hFF);
      bus(1'b0, ADDR_LINE_STATUS, 32'h60, 32'h61);
      bus(1'b1, ADDR_MODEM_CONTROL, 32'h0, '0);
      bus(1'b1, ADDR_LINE_FORMAT, 32'h43, '0);
      repeat (2) @(posedge hclk);
      chk(tx_out, 1'b0);
      // Break is lifted before listening, else it reads as a frame
      bus(1'b1, ADDR_LINE_FORMAT, 32'h03, '0);
      repeat (2) @(posedge hclk);
      listen <= 1'b1;
      foreach (fmts[k])
      begin
         v = $random(seed);
         bus(1'b1, ADDR_LINE_FORMAT, fmts[k], '0);
         expq.push_back(mkf(fmts[k], v[7:0]));
         bus(1'b1, ADDR_DATA, v & 32'hFF, '0);
         bus(1'b0, ADDR_LINE_STATUS, 32'h0, 32'h40);
         repeat (3400) @(posedge hclk);
      end
      end_of_test(0);
   end
endmodule : test_uart_line_modem_control_status
